/* File: design/ifb_pkg.sv */
package ifb_pkg;
    // ************************************************************
    // register map: offsets chosen, one aligned word each
    // ************************************************************
    localparam logic [5:0] OFS_HALL_EDGE = 6'h00;
    localparam logic [5:0] OFS_LINE_EDGE = 6'h04;
    localparam logic [5:0] OFS_FILT_EDGE = 6'h08;
    localparam logic [5:0] OFS_PRI0      = 6'h0C;
    localparam logic [5:0] OFS_PRI1      = 6'h10;
    localparam logic [5:0] OFS_PRI2      = 6'h14;
    localparam logic [5:0] OFS_PRI3      = 6'h18;
    localparam logic [5:0] OFS_GRP0      = 6'h1C;
    localparam logic [5:0] OFS_GRP1      = 6'h20;
    localparam logic [5:0] OFS_GRP2      = 6'h24;
    localparam logic [5:0] OFS_GRP3      = 6'h28;
    localparam logic [5:0] OFS_GRP4      = 6'h2C;
    localparam logic [5:0] OFS_GRP5      = 6'h30;
    localparam logic [5:0] OFS_GRP6      = 6'h34;
    localparam logic [5:0] OFS_PENDING   = 6'h38;
    localparam logic [5:0] OFS_ACK       = 6'h3C;

    // ************************************************************
    // implemented-bit masks and reset value
    // ************************************************************
    localparam logic [7:0] MSK_HALL_EDGE = 8'h03;
    localparam logic [7:0] MSK_LINE_EDGE = 8'h03;
    localparam logic [7:0] MSK_FILT_EDGE = 8'hC0;
    localparam logic [7:0] MSK_PRI0      = 8'h7F;
    localparam logic [7:0] MSK_PRI1      = 8'hFF;
    localparam logic [7:0] MSK_PRI2      = 8'hFF;
    localparam logic [7:0] MSK_PRI3      = 8'hDD;
    localparam logic [7:0] MSK_GRP0      = 8'h11;
    localparam logic [7:0] MSK_GRP1      = 8'hFF;
    localparam logic [7:0] MSK_GRP2      = 8'hBB;
    localparam logic [7:0] MSK_GRPT      = 8'h33;
    localparam logic [7:0] RST_BYTE      = 8'h00;

    // ************************************************************
    // edge-select codes and field positions
    // ************************************************************
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam int FILT_EDGE_LSB = 6;
    localparam int FLAG_LSB      = 4;

    // primary register bit positions
    localparam int P0_CMP_F = 6;
    localparam int P0_LIN_F = 5;
    localparam int P0_G0_F  = 4;
    localparam int P0_CMP_E = 3;
    localparam int P0_LIN_E = 2;
    localparam int P0_G0_E  = 1;
    localparam int P0_GIE   = 0;
    localparam int P1_OC_F  = 7;
    localparam int P1_LV_F  = 6;
    localparam int P1_G1_F  = 5;
    localparam int P1_NF_F  = 4;
    localparam int P1_OC_E  = 3;
    localparam int P1_LV_E  = 2;
    localparam int P1_G1_E  = 1;
    localparam int P1_NF_E  = 0;
    localparam int P3_TB_F  = 7;
    localparam int P3_G6_F  = 6;
    localparam int P3_UR_F  = 4;
    localparam int P3_TB_E  = 3;
    localparam int P3_G6_E  = 2;
    localparam int P3_UR_E  = 0;

    // vector numbers reported to the core (chosen order)
    localparam logic [4:0] VEC_NONE = 5'h1F;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ifb_pkg

/* File: design/ifb_edge_det.sv */
`timescale 1ns/100ps
// ************************************************************
// synchronised edge detector with two-bit trigger select
// ************************************************************
module ifb_edge_det
    import ifb_pkg::*;
(
    // clock and control
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       clk_en,
    // signal and select
    input  wire logic       sig_in,
    input  wire logic [1:0] edge_sel,
    // event out
    output logic            hit
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic rise;
    logic fall;

    // two-stage sync, third stage for edge history
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (clk_en) begin
            s1_q <= sig_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;

    // decode the trigger select
    always_comb begin
        unique case (edge_sel)
            EDGE_OFF:  hit = 1'b0;
            EDGE_RISE: hit = clk_en & rise;
            EDGE_FALL: hit = clk_en & fall;
            EDGE_BOTH: hit = clk_en & (rise | fall);
        endcase
    end
endmodule : ifb_edge_det

/* File: design/ifb_bank.sv */
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module ifb_bank
    import ifb_pkg::*;
(
    // clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    // axi4-lite write
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pin-level event inputs (asynchronous)
    input  wire logic        filtered_hall_signal,
    input  wire logic        line_input,
    input  wire logic        noise_filtered_input,
    // one-cycle event pulses from on-chip logic
    input  wire logic        ev_comparator0,
    input  wire logic        ev_overcurrent,
    input  wire logic        ev_low_voltage,
    input  wire logic        ev_time_base,
    input  wire logic        ev_serial_port,
    input  wire logic [3:0]  ev_capture_adc,
    input  wire logic [2:0]  ev_pwm,
    input  wire logic [1:0]  ev_timer1,
    input  wire logic [1:0]  ev_periodic_timer,
    input  wire logic [1:0]  ev_timer0,
    input  wire logic [1:0]  ev_timer2,
    // core side
    input  wire logic        irq_take,
    output logic             irq_req_q,
    output logic [4:0]       irq_vector_q
);
    logic [7:0] hall_edge_q, line_edge_q, filt_edge_q;
    logic [7:0] pri0_q, pri1_q, pri2_q, pri3_q;
    logic [7:0] grp_q [0:6];
    logic       hall_hit, line_hit, filt_hit;
    logic [7:0] wbyte;
    logic       wr_go, rd_go, wr_hit, rd_hit;
    logic [5:0] aw_q, ar_q;
    logic       aw_full_q, w_full_q;
    logic [7:0] wd_q;
    logic       wb_q;
    logic [7:0] rd_byte;
    logic [6:0] grp_set;
    logic [7:0] pri0_set, pri1_set, pri2_set, pri3_set;
    logic [7:0] ev_grp [0:6];
    logic [13:0] pend;
    logic [4:0] vec_d;

    // ************************************************************
    // edge detectors on the three pin inputs
    // ************************************************************
    ifb_edge_det u_hall (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .sig_in   (filtered_hall_signal),
        .edge_sel (hall_edge_q[1:0]),
        .hit      (hall_hit)
    );
    ifb_edge_det u_line (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .sig_in   (line_input),
        .edge_sel (line_edge_q[1:0]),
        .hit      (line_hit)
    );
    ifb_edge_det u_filt (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .sig_in   (noise_filtered_input),
        .edge_sel (filt_edge_q[FILT_EDGE_LSB+1:FILT_EDGE_LSB]),
        .hit      (filt_hit)
    );

    // ************************************************************
    // axi4-lite slave: capture address and data in any order
    // ************************************************************
    assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign rd_go = s_axi_arvalid & s_axi_arready;

    // write channel holding
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_q      <= '0;
            wd_q      <= RST_BYTE;
            wb_q      <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_q      <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_full_q <= 1'b1;
                wd_q     <= s_axi_wdata[7:0];
                wb_q     <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (clk_en) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign wr_hit = (aw_q <= OFS_ACK) & (aw_q[1:0] == 2'h0) & (aw_q != OFS_PENDING);
    assign rd_hit = (s_axi_araddr <= OFS_PENDING) & (s_axi_araddr[1:0] == 2'h0);
    assign wbyte  = wd_q;

    // ************************************************************
    // event routing into flag set vectors
    // ************************************************************
    always_comb begin
        ev_grp[0] = {3'h0, hall_hit, 4'h0};
        ev_grp[1] = {ev_capture_adc, 4'h0};
        ev_grp[2] = {ev_pwm[2], 1'b0, ev_pwm[1:0], 4'h0};
        ev_grp[3] = {2'h0, ev_timer1, 4'h0};
        ev_grp[4] = {2'h0, ev_periodic_timer, 4'h0};
        ev_grp[5] = {2'h0, ev_timer0, 4'h0};
        ev_grp[6] = {2'h0, ev_timer2, 4'h0};
    end

    // group flag raised by any enabled pending sub-flag
    always_comb begin
        for (int g = 0; g < 7; g++) begin
            grp_set[g] = |(grp_q[g][7:4] & grp_q[g][3:0]);
        end
    end

    // primary flag set vectors; flags set whatever the enable
    always_comb begin
        pri0_set = '0;
        pri0_set[P0_CMP_F] = ev_comparator0;
        pri0_set[P0_LIN_F] = line_hit;
        pri0_set[P0_G0_F]  = grp_set[0];
        pri1_set = '0;
        pri1_set[P1_OC_F]  = ev_overcurrent;
        pri1_set[P1_LV_F]  = ev_low_voltage;
        pri1_set[P1_G1_F]  = grp_set[1];
        pri1_set[P1_NF_F]  = filt_hit;
        pri2_set = {grp_set[5], grp_set[4], grp_set[3], grp_set[2], 4'h0};
        pri3_set = '0;
        pri3_set[P3_TB_F]  = ev_time_base;
        pri3_set[P3_G6_F]  = grp_set[6];
        pri3_set[P3_UR_F]  = ev_serial_port;
    end

    // ************************************************************
    // pending requests and vector pick (lowest index first)
    // ************************************************************
    always_comb begin
        pend[0]  = pri0_q[P0_CMP_F] & pri0_q[P0_CMP_E];
        pend[1]  = pri0_q[P0_LIN_F] & pri0_q[P0_LIN_E];
        pend[2]  = pri0_q[P0_G0_F]  & pri0_q[P0_G0_E];
        pend[3]  = pri1_q[P1_OC_F]  & pri1_q[P1_OC_E];
        pend[4]  = pri1_q[P1_LV_F]  & pri1_q[P1_LV_E];
        pend[5]  = pri1_q[P1_G1_F]  & pri1_q[P1_G1_E];
        pend[6]  = pri1_q[P1_NF_F]  & pri1_q[P1_NF_E];
        pend[10:7] = pri2_q[7:4] & pri2_q[3:0];
        pend[11] = pri3_q[P3_TB_F]  & pri3_q[P3_TB_E];
        pend[12] = pri3_q[P3_G6_F]  & pri3_q[P3_G6_E];
        pend[13] = pri3_q[P3_UR_F]  & pri3_q[P3_UR_E];
        vec_d = VEC_NONE;
        for (int i = 13; i >= 0; i--) begin
            if (pend[i]) begin
                vec_d = 5'(i);
            end
        end
    end

    // request to core gated by the global enable
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_req_q    <= 1'b0;
            irq_vector_q <= VEC_NONE;
        end else if (clk_en) begin
            irq_req_q    <= pri0_q[P0_GIE] & ~irq_take & (|pend);
            irq_vector_q <= vec_d;
        end
    end

    // ************************************************************
    // edge-select registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hall_edge_q <= RST_BYTE;
            line_edge_q <= RST_BYTE;
            filt_edge_q <= RST_BYTE;
        end else if (clk_en & wr_go & wb_q) begin
            if (aw_q == OFS_HALL_EDGE) hall_edge_q <= wbyte & MSK_HALL_EDGE;
            if (aw_q == OFS_LINE_EDGE) line_edge_q <= wbyte & MSK_LINE_EDGE;
            if (aw_q == OFS_FILT_EDGE) filt_edge_q <= wbyte & MSK_FILT_EDGE;
        end
    end

    // ************************************************************
    // primary registers: write then set-wins, global enable auto-clear
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pri0_q <= RST_BYTE;
            pri1_q <= RST_BYTE;
            pri2_q <= RST_BYTE;
            pri3_q <= RST_BYTE;
        end else if (clk_en) begin
            logic [7:0] p0, p1, p2, p3;
            p0 = pri0_q;
            p1 = pri1_q;
            p2 = pri2_q;
            p3 = pri3_q;
            if (wr_go & wb_q) begin
                if (aw_q == OFS_PRI0) p0 = wbyte & MSK_PRI0;
                if (aw_q == OFS_PRI1) p1 = wbyte & MSK_PRI1;
                if (aw_q == OFS_PRI2) p2 = wbyte & MSK_PRI2;
                if (aw_q == OFS_PRI3) p3 = wbyte & MSK_PRI3;
            end
            if (irq_take) begin
                p0[P0_GIE] = 1'b0;
            end
            pri0_q <= p0 | pri0_set;
            pri1_q <= p1 | pri1_set;
            pri2_q <= p2 | pri2_set;
            pri3_q <= p3 | pri3_set;
        end
    end

    // ************************************************************
    // group registers: software-cleared sub-flags, set wins
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int g = 0; g < 7; g++) begin
                grp_q[g] <= RST_BYTE;
            end
        end else if (clk_en) begin
            for (int g = 0; g < 7; g++) begin
                logic [7:0] gv;
                logic [7:0] gm;
                gv = grp_q[g];
                gm = (g == 0) ? MSK_GRP0 : (g == 1) ? MSK_GRP1 :
                     (g == 2) ? MSK_GRP2 : MSK_GRPT;
                if (wr_go & wb_q & (aw_q == 6'(OFS_GRP0 + 6'(4 * g)))) begin
                    gv = wbyte & gm;
                end
                grp_q[g] <= (gv | ev_grp[g]) & gm;
            end
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb begin
        rd_byte = RST_BYTE;
        unique case (s_axi_araddr)
            OFS_HALL_EDGE: rd_byte = hall_edge_q;
            OFS_LINE_EDGE: rd_byte = line_edge_q;
            OFS_FILT_EDGE: rd_byte = filt_edge_q;
            OFS_PRI0:      rd_byte = pri0_q;
            OFS_PRI1:      rd_byte = pri1_q;
            OFS_PRI2:      rd_byte = pri2_q;
            OFS_PRI3:      rd_byte = pri3_q;
            OFS_GRP0:      rd_byte = grp_q[0];
            OFS_GRP1:      rd_byte = grp_q[1];
            OFS_GRP2:      rd_byte = grp_q[2];
            OFS_GRP3:      rd_byte = grp_q[3];
            OFS_GRP4:      rd_byte = grp_q[4];
            OFS_GRP5:      rd_byte = grp_q[5];
            OFS_GRP6:      rd_byte = grp_q[6];
            OFS_PENDING:   rd_byte = {3'h0, irq_vector_q};
            default:       rd_byte = RST_BYTE;
        endcase
    end

    // read response register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (clk_en) begin
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h0, rd_byte};
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : ifb_bank

/* File: testbench/ifb_bank_chk.sv */
`timescale 1ns/100ps
// ************************************************************
// port-level checks of the flag and enable bank
// ************************************************************
module ifb_bank_chk
    import ifb_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // core side
    input wire logic        irq_take,
    input wire logic        irq_req_q,
    input wire logic [4:0]  irq_vector_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // outputs quiet right after reset
    reset_quiet_a: assert property ($fell(srst) |-> !irq_req_q
        && irq_vector_q == VEC_NONE && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
    // a request always names a source
    req_vector_a: assert property (irq_req_q |-> irq_vector_q != VEC_NONE)
        else $error("request without vector");
    // taking the interrupt drops the request
    take_drop_a: assert property (irq_take |=> !irq_req_q)
        else $error("request stays after take");
    // write response held until accepted
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    // read response held until accepted
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read response dropped");
    // unused upper data bits read zero
    r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // no new read while a response waits
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    // read answer on the next edge
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // write answer within two edges
    b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
endmodule : ifb_bank_chk

/* File: testbench/ifb_core_model.sv */
`timescale 1ns/100ps
// ************************************************************
// core model: takes a pending request when allowed
// ************************************************************
module ifb_core_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // request handshake
    input wire logic irq_req_q,
    input wire logic accept_en,
    output logic     irq_take
);
    // one-cycle take per request
    always_ff @(posedge ref_clk) begin
        irq_take <= !srst && accept_en && irq_req_q && !irq_take;
    end
endmodule : ifb_core_model

/* File: testbench/ifb_bank_tb_top.sv */
`timescale 1ns/100ps
// ************************************************************
// bench for the flag and enable bank
// ************************************************************
module ifb_bank_tb_top;
    import ifb_pkg::*;
    logic        ref_clk, srst, clk_en, awvalid, wvalid, bready, arvalid, rready, accept_en;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, irq_take, irq_req_q;
    logic [4:0]  irq_vector_q;
    logic [2:0]  pins;
    logic [19:0] ev;
    int          miscompares, n_checks, cycles;
    logic [7:0]  msk [14] = '{MSK_HALL_EDGE, MSK_LINE_EDGE, MSK_FILT_EDGE, MSK_PRI0, MSK_PRI1,
        MSK_PRI2, MSK_PRI3, MSK_GRP0, MSK_GRP1, MSK_GRP2, MSK_GRPT, MSK_GRPT, MSK_GRPT, MSK_GRPT};
    logic [5:0]  ev_ofs [9] = '{6'h0C, 6'h10, 6'h18, 6'h20, 6'h24, 6'h28, 6'h2C, 6'h30, 6'h34};
    logic [7:0]  ev_exp [9] = '{8'h40, 8'hC0, 8'h90, 8'hF0, 8'hB0, 8'h30, 8'h30, 8'h30, 8'h30};

    ifb_bank u_ifb_bank (.ref_clk, .srst, .clk_en, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .filtered_hall_signal(pins[0]), .line_input(pins[1]), .noise_filtered_input(pins[2]),
        .ev_comparator0(ev[19]), .ev_overcurrent(ev[18]), .ev_low_voltage(ev[17]),
        .ev_time_base(ev[16]), .ev_serial_port(ev[15]), .ev_capture_adc(ev[14:11]),
        .ev_pwm(ev[10:8]), .ev_timer1(ev[7:6]), .ev_periodic_timer(ev[5:4]),
        .ev_timer0(ev[3:2]), .ev_timer2(ev[1:0]), .irq_take, .irq_req_q, .irq_vector_q);
    ifb_core_model u_ifb_core_model (.ref_clk, .srst, .irq_req_q, .accept_en, .irq_take);

    // clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // bus write: address and data offered together, bready held until bvalid
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            done = bvalid && bready;
            if (done) check({30'h0, bresp}, {30'h0, er});
        end
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    // bus read: rready held until rvalid, data taken at that edge
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        logic done;
        done = 1'b0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            done = rvalid && rready;
            if (done) check(rdata, {24'h0, exp});
            if (done) check({30'h0, rresp}, {30'h0, RESP_OKAY});
        end
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask : rd

    // all four trigger codes on one pin, both edge directions
    task automatic edge_case(input int p, input logic [5:0] so, input int sh,
                             input logic [5:0] fo, input int fb);
        logic [7:0] e;
        for (int c = 0; c < 4; c++) begin
            wr(so, 8'(c << sh), RESP_OKAY);
            wr(fo, 8'h00, RESP_OKAY);
            pins[p] <= 1'b1;
            repeat (8) @(posedge ref_clk);
            e = 8'h00;
            e[fb] = c[0];
            rd(fo, e);
            wr(fo, 8'h00, RESP_OKAY);
            pins[p] <= 1'b0;
            repeat (8) @(posedge ref_clk);
            e[fb] = c[1];
            rd(fo, e);
        end
    endtask : edge_case

    // main sequence
    initial begin
        {srst, clk_en, awvalid, wvalid, bready, arvalid, rready, accept_en} <= 8'hC0;
        {awaddr, araddr, wdata, pins, ev} <= '0;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 14; i++) rd(6'(4 * i), RST_BYTE);
        for (int i = 0; i < 14; i++) wr(6'(4 * i), 8'hFF, RESP_OKAY);
        for (int i = 0; i < 14; i++) rd(6'(4 * i), msk[i]);
        for (int i = 13; i >= 0; i--) wr(6'(4 * i), 8'h00, RESP_OKAY);
        wr(6'h0D, 8'hFF, RESP_SLVERR);
        rd(6'h0C, 8'h00);
        // every on-chip event source sets its flag with enables off; the three pins stay low
        ev <= 20'hFFFFF;
        @(posedge ref_clk);
        ev <= '0;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++) rd(ev_ofs[i], ev_exp[i]);
        rd(6'h14, 8'h00);
        for (int i = 0; i < 9; i++) wr(ev_ofs[i], 8'h00, RESP_OKAY);
        // enabled sub-flag raises its group flag and stays until cleared
        wr(6'h24, 8'h08, RESP_OKAY);
        ev <= 20'h00400;
        @(posedge ref_clk);
        ev <= '0;
        repeat (6) @(posedge ref_clk);
        rd(6'h24, 8'h88);
        rd(6'h14, 8'h10);
        rd(6'h24, 8'h88);
        wr(6'h24, 8'h00, RESP_OKAY);
        wr(6'h14, 8'h00, RESP_OKAY);
        rd(6'h14, 8'h00);
        // request gated by global enable, take clears it, flag kept
        ev <= 20'h80000;
        @(posedge ref_clk);
        ev <= '0;
        wr(6'h0C, 8'h48, RESP_OKAY);
        repeat (4) @(posedge ref_clk);
        check({31'h0, irq_req_q}, 32'h0);
        wr(6'h0C, 8'h49, RESP_OKAY);
        repeat (3) @(posedge ref_clk);
        check({31'h0, irq_req_q}, 32'h1);
        check({27'h0, irq_vector_q}, 32'h0);
        accept_en <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd(6'h0C, 8'h48);
        check({31'h0, irq_req_q}, 32'h0);
        accept_en <= 1'b0;
        wr(6'h0C, 8'h00, RESP_OKAY);
        // low clock enable freezes the flags against an event pulse
        clk_en <= 1'b0;
        ev <= 20'h80000;
        @(posedge ref_clk);
        ev <= '0;
        clk_en <= 1'b1;
        @(posedge ref_clk);
        rd(6'h0C, 8'h00);
        edge_case(1, 6'h04, 0, 6'h0C, 5);
        edge_case(0, 6'h00, 0, 6'h1C, 4);
        edge_case(2, 6'h08, 6, 6'h10, 4);
        conclude();
    end
endmodule : ifb_bank_tb_top

bind ifb_bank ifb_bank_chk u_ifb_bank_chk (.ref_clk, .srst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_take, .irq_req_q,
    .irq_vector_q);
